// [hqt_crc32_step.v]
// One-byte step of the reflected Ethernet CRC-32
`timescale 1ns/1ps
`default_nettype none
`include "hqt_tx_queue_ctrl_regs.vh"
module hqt_crc32_step (
  input wire [31:0] crc_i,
  input wire [7:0] data_i,
  output reg [31:0] crc_o
);
  integer i;
  always @* begin
    crc_o = crc_i;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_o[0] ^ data_i[i]) begin
        crc_o = (crc_o >> 1) ^ `HQT_CRC_POLY;
      end else begin
        crc_o = crc_o >> 1;
      end
    end
  end
endmodule // hqt_crc32_step
`default_nettype wire

// [hqt_mac_model.sv]
// Behavioural MAC that takes the byte stream and reports completion
`timescale 1ns/1ps
`default_nettype none
module hqt_mac_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Byte stream and test controls
  input wire logic [7:0] data_i,
  input wire logic last_i,
  input wire logic valid_i,
  input wire logic slow_i,
  input wire logic [1:0] col_i,
  // Acceptance and completion
  output logic ready_o,
  output logic done_o,
  output logic [1:0] col_o
);
  logic [7:0] bytes [0:79];
  int cnt;
  int len;
  int nf;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      done_o <= 1'b0;
      col_o <= 2'b00;
      cnt <= 0;
      len <= 0;
      nf <= 0;
    end else begin
      ready_o <= slow_i ? ~ready_o : 1'b1;
      done_o <= valid_i && ready_o && last_i;
      // Toggle outside done so a stale value never looks valid
      col_o <= (valid_i && ready_o && last_i) ? col_i : ~col_o;
      if (valid_i && ready_o) begin
        bytes[cnt] <= data_i;
        cnt <= last_i ? 0 : cnt + 1;
        if (last_i) len <= cnt + 1;
        if (last_i) nf <= nf + 1;
      end
    end
  end
endmodule // hqt_mac_model
`default_nettype wire

// [hqt_two_entry_buf.v]
// Two-entry buffer with valid/ready on both sides and a flush input
`timescale 1ns/1ps
`default_nettype none
module hqt_two_entry_buf #(
  parameter WIDTH = 15
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire flush_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] cnt_reg;
  reg in_ready_reg;
  wire [1:0] cnt_next;
  wire push;
  wire pop;

  // Registered ready; a word offered in the first flush cycle is dropped with the rest
  assign in_ready_o = in_ready_reg;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  assign out_valid_o = (cnt_reg != 2'd0) && !flush_i;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'd0;
      in_ready_reg <= 1'b1;
    end else if (flush_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'd0;
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= (cnt_next != 2'd2);
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_next;
    end
  end
endmodule // hqt_two_entry_buf
`default_nettype wire

// [hqt_tx_queue_ctrl.v]
// Transmit queue control: registers, frame engine, flow control and status
//
// Contract
// (RQ1) ICMP checksum generation enable bit 8 requests ICMP checksum insertion.
// (RQ2) UDP checksum generation enable bit 7 requests UDP checksum insertion.
// (RQ3) TCP checksum generation enable bit 6 requests TCP checksum insertion.
// (RQ4) Transmit flush bit 5 clears the transmit queue and frame pointer.
// (RQ5) Host clears transmit enable before flushing, then clears flush.
// (RQ6) Full duplex with flow control bit 4: send PAUSE at receive threshold.
// (RQ7) Half duplex with flow control bit: apply back-pressure instead.
// (RQ8) Flow control bit clear: no PAUSE and no back-pressure.
// (RQ9) Padding bit 3 extends packets shorter than 64 bytes.
// (RQ10) Host enables CRC append whenever padding is enabled.
// (RQ11) CRC bit 2 appends a 32-bit CRC to every frame.
// (RQ12) Transmit enable bit 0 puts the transmitter into running state.
// (RQ13) Clearing enable finishes the current frame, then stops.
// (RQ14) Status bit 13 shows a late collision.
// (RQ15) Status bit 12 shows maximum collision count reached.
// (RQ16) Status bits 5..0 give last frame ID; collision bits belong to it. Code stores cur_fid_reg, the next frame's ID if it started before done.
// (RQ17) Receive control bit 15 flushes the receive queue and pointer.
// (RQ18) Host clears receive enable before flushing, then clears flush.
// (RQ19) Full duplex with receive flow control: received PAUSE holds transmission.
// (RQ20) Status is overwritten at each frame completion.
`timescale 1ns/1ps
`default_nettype none
`include "hqt_tx_queue_ctrl_regs.vh"
module hqt_tx_queue_ctrl #(
  parameter FID_W = `HQT_FID_W
) (
  // Clock and reset
  input wire SYS_CLK_I,
  input wire RSTN_I,
  // Register port
  input wire [`HQT_ADDR_W-1:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [1:0] REG_BE_I,
  input wire [15:0] REG_WDATA_I,
  output reg [15:0] REG_RDATA_O,
  // Frames from the queue
  input wire [7:0] IN_DATA_I,
  input wire IN_LAST_I,
  input wire [FID_W-1:0] IN_FID_I,
  input wire IN_VALID_I,
  output wire IN_READY_O,
  // Bytes toward the MAC
  output reg [7:0] TX_DATA_O,
  output reg TX_LAST_O,
  output reg TX_VALID_O,
  input wire TX_READY_I,
  // Completion status from the MAC
  input wire TX_DONE_I,
  input wire TX_LATE_COL_I,
  input wire TX_MAX_COL_I,
  // Flow control
  input wire FULL_DUPLEX_I,
  input wire RX_BUF_HIGH_I,
  input wire RX_PAUSE_I,
  input wire [15:0] RX_PAUSE_QUANTA_I,
  output reg PAUSE_REQ_O,
  output reg BACKPRESSURE_O,
  // Per-frame checksum requests and queue control
  output reg TX_CSUM_ICMP_O,
  output reg TX_CSUM_UDP_O,
  output reg TX_CSUM_TCP_O,
  output reg TX_FLUSH_O,
  output reg RX_FLUSH_O,
  output reg RX_ENABLE_O,
  output reg TX_RUNNING_O
);
  localparam BUF_W = 8 + 1 + FID_W;
  localparam S_IDLE = 4'b0001;
  localparam S_DATA = 4'b0010;
  localparam S_PAD = 4'b0100;
  localparam S_CRC = 4'b1000;
  localparam integer QUANTUM_INT = `HQT_PAUSE_QUANTUM_CYC;
  localparam [9:0] QUANTUM_CYC = QUANTUM_INT[9:0];

  reg [15:0] tx_ctrl_reg;
  reg [15:0] rx_ctrl_reg;
  reg late_col_reg;
  reg max_col_reg;
  reg [FID_W-1:0] stat_fid_reg;
  reg [FID_W-1:0] cur_fid_reg;
  reg [3:0] state_reg;
  reg [6:0] cnt_reg;
  reg [2:0] crc_idx_reg;
  reg [31:0] crc_reg;
  reg crc_on_reg;
  reg pad_on_reg;
  reg [15:0] quanta_reg;
  reg [9:0] qcyc_reg;
  reg rx_high_reg;

  wire [15:0] wmask;
  wire [15:0] tx_ctrl_next;
  wire [15:0] rx_ctrl_next;
  wire tx_flush;
  wire tx_en;
  wire flow_en;
  wire paused;
  wire can_load;
  wire [BUF_W-1:0] buf_data;
  wire buf_valid;
  reg buf_pop;
  wire [7:0] b_byte;
  wire b_last;
  wire [7:0] crc_din;
  wire [31:0] crc_step;
  reg crc_adv;
  wire [31:0] crc_fin;

  assign wmask = {{8{REG_BE_I[1]}}, {8{REG_BE_I[0]}}};
  assign tx_ctrl_next = (tx_ctrl_reg & ~(wmask & `HQT_TXC_WR_MASK)) |
                        (REG_WDATA_I & wmask & `HQT_TXC_WR_MASK);
  assign rx_ctrl_next = (rx_ctrl_reg & ~wmask) | (REG_WDATA_I & wmask);
  assign tx_flush = tx_ctrl_reg[`HQT_TXC_FLUSH];
  assign tx_en = tx_ctrl_reg[`HQT_TXC_ENABLE];
  assign flow_en = tx_ctrl_reg[`HQT_TXC_FLOW_CTRL];
  assign paused = (quanta_reg != 16'h0000) && FULL_DUPLEX_I &&
                  rx_ctrl_reg[`HQT_RXC_FLOW_CTRL];
  assign can_load = !TX_VALID_O || TX_READY_I;
  assign b_byte = buf_data[7:0];
  assign b_last = buf_data[8];
  assign crc_din = (state_reg == S_DATA) ? b_byte : 8'h00;
  assign crc_fin = ~crc_reg;

  // Flush holds the buffer empty and, from its second cycle, holds ready low toward the queue
  hqt_two_entry_buf #(
    .WIDTH(BUF_W)
  ) u_buf (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RSTN_I),
    .flush_i(tx_flush), // see (RQ4)
    .in_data_i({IN_FID_I, IN_LAST_I, IN_DATA_I}),
    .in_valid_i(IN_VALID_I),
    .in_ready_o(IN_READY_O),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  hqt_crc32_step u_crc (
    .crc_i(crc_reg),
    .data_i(crc_din),
    .crc_o(crc_step)
  );

  // Register writes and read-back
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_ctrl_reg <= `HQT_TXC_RESET;
      rx_ctrl_reg <= `HQT_RXC_RESET;
      REG_RDATA_O <= 16'h0000;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `HQT_OFS_TX_CTRL) begin
        tx_ctrl_reg <= tx_ctrl_next;
      end
      if (REG_WR_I && REG_ADDR_I == `HQT_OFS_RX_CTRL1) begin
        rx_ctrl_reg <= rx_ctrl_next;
      end
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `HQT_OFS_TX_CTRL: REG_RDATA_O <= tx_ctrl_reg;
          `HQT_OFS_TX_STAT: begin
            REG_RDATA_O <= 16'h0000;
            REG_RDATA_O[`HQT_TXS_LATE_COL] <= late_col_reg; // see (RQ14)
            REG_RDATA_O[`HQT_TXS_MAX_COL] <= max_col_reg; // see (RQ15)
            REG_RDATA_O[`HQT_TXS_FID_HI:`HQT_TXS_FID_LO] <= stat_fid_reg; // see (RQ16)
          end
          `HQT_OFS_RX_CTRL1: REG_RDATA_O <= rx_ctrl_reg;
          default: REG_RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  // Collision bits belong to the frame just completed, the ID to the frame last started; replaced each time
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      late_col_reg <= 1'b0;
      max_col_reg <= 1'b0;
      stat_fid_reg <= {FID_W{1'b0}};
    end else if (TX_DONE_I) begin
      late_col_reg <= TX_LATE_COL_I; // see (RQ14) (RQ20)
      max_col_reg <= TX_MAX_COL_I; // see (RQ15) (RQ20)
      stat_fid_reg <= cur_fid_reg; // see (RQ16) (RQ20)
    end
  end

  // Queue controls and flow control outputs
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TX_FLUSH_O <= 1'b0;
      RX_FLUSH_O <= 1'b0;
      RX_ENABLE_O <= 1'b0;
      PAUSE_REQ_O <= 1'b0;
      BACKPRESSURE_O <= 1'b0;
      rx_high_reg <= 1'b0;
      TX_RUNNING_O <= 1'b0;
    end else begin
      TX_FLUSH_O <= tx_flush; // see (RQ4)
      RX_FLUSH_O <= rx_ctrl_reg[`HQT_RXC_FLUSH]; // see (RQ17)
      RX_ENABLE_O <= rx_ctrl_reg[`HQT_RXC_ENABLE];
      rx_high_reg <= RX_BUF_HIGH_I;
      // One PAUSE per crossing of the threshold
      PAUSE_REQ_O <= flow_en && FULL_DUPLEX_I && RX_BUF_HIGH_I && !rx_high_reg; // see (RQ6) (RQ8)
      BACKPRESSURE_O <= flow_en && !FULL_DUPLEX_I && RX_BUF_HIGH_I; // see (RQ7) (RQ8)
      TX_RUNNING_O <= tx_en || (state_reg != S_IDLE); // see (RQ12) (RQ13)
    end
  end

  // Received pause time, counted in quanta of 512 bit times
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      quanta_reg <= 16'h0000;
      qcyc_reg <= 10'd0;
    end else if (RX_PAUSE_I) begin
      quanta_reg <= RX_PAUSE_QUANTA_I; // see (RQ19)
      qcyc_reg <= 10'd0;
    end else if (quanta_reg != 16'h0000) begin
      if (qcyc_reg == QUANTUM_CYC - 10'd1) begin
        qcyc_reg <= 10'd0;
        quanta_reg <= quanta_reg - 16'h0001;
      end else begin
        qcyc_reg <= qcyc_reg + 10'd1;
      end
    end
  end

  always @* begin
    buf_pop = 1'b0;
    crc_adv = 1'b0;
    if (can_load) begin
      case (state_reg)
        S_DATA: begin
          buf_pop = buf_valid;
          crc_adv = buf_valid;
        end
        S_PAD: crc_adv = 1'b1;
        default: crc_adv = 1'b0;
      endcase
    end
  end

  // Frame engine
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= S_IDLE;
      cnt_reg <= 7'd0;
      crc_idx_reg <= 3'd0;
      crc_reg <= `HQT_CRC_INIT;
      crc_on_reg <= 1'b0;
      pad_on_reg <= 1'b0;
      cur_fid_reg <= {FID_W{1'b0}};
      TX_DATA_O <= 8'h00;
      TX_LAST_O <= 1'b0;
      TX_VALID_O <= 1'b0;
      TX_CSUM_ICMP_O <= 1'b0;
      TX_CSUM_UDP_O <= 1'b0;
      TX_CSUM_TCP_O <= 1'b0;
    end else if (tx_flush) begin
      state_reg <= S_IDLE; // see (RQ4)
      cnt_reg <= 7'd0;
      TX_VALID_O <= 1'b0;
      TX_LAST_O <= 1'b0;
    end else begin
      if (can_load) begin
        TX_VALID_O <= 1'b0;
        TX_LAST_O <= 1'b0;
      end
      if (crc_adv) begin
        crc_reg <= crc_step;
        cnt_reg <= cnt_reg + 7'd1;
      end
      case (state_reg)
        S_IDLE: begin
          // New frames start only while enabled and not paused
          if (tx_en && !paused && buf_valid) begin // see (RQ12) (RQ13) (RQ19)
            state_reg <= S_DATA;
            cnt_reg <= 7'd0;
            crc_reg <= `HQT_CRC_INIT;
            crc_on_reg <= tx_ctrl_reg[`HQT_TXC_CRC];
            pad_on_reg <= tx_ctrl_reg[`HQT_TXC_PAD];
            cur_fid_reg <= buf_data[BUF_W-1:9];
            TX_CSUM_ICMP_O <= tx_ctrl_reg[`HQT_TXC_ICMP_CSUM]; // see (RQ1)
            TX_CSUM_UDP_O <= tx_ctrl_reg[`HQT_TXC_UDP_CSUM]; // see (RQ2)
            TX_CSUM_TCP_O <= tx_ctrl_reg[`HQT_TXC_TCP_CSUM]; // see (RQ3)
          end
        end
        S_DATA: begin
          if (can_load && buf_valid) begin
            TX_DATA_O <= b_byte;
            TX_VALID_O <= 1'b1;
            if (b_last) begin
              if (pad_on_reg && cnt_reg + 7'd1 < `HQT_MIN_DATA_BYTES) begin
                state_reg <= S_PAD; // see (RQ9)
              end else if (crc_on_reg) begin
                state_reg <= S_CRC; // see (RQ11)
                crc_idx_reg <= 3'd0;
              end else begin
                TX_LAST_O <= 1'b1;
                state_reg <= S_IDLE;
              end
            end
          end
        end
        S_PAD: begin
          if (can_load) begin
            TX_DATA_O <= 8'h00; // see (RQ9)
            TX_VALID_O <= 1'b1;
            if (cnt_reg + 7'd1 == `HQT_MIN_DATA_BYTES) begin
              if (crc_on_reg) begin
                state_reg <= S_CRC;
                crc_idx_reg <= 3'd0;
              end else begin
                // Host left CRC off; frame ends short of a valid FCS
                TX_LAST_O <= 1'b1;
                state_reg <= S_IDLE;
              end
            end
          end
        end
        S_CRC: begin
          if (can_load) begin
            TX_DATA_O <= crc_fin[{crc_idx_reg[1:0], 3'b000} +: 8]; // see (RQ11)
            TX_VALID_O <= 1'b1;
            crc_idx_reg <= crc_idx_reg + 3'd1;
            if (crc_idx_reg == `HQT_CRC_BYTES - 3'd1) begin
              TX_LAST_O <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // hqt_tx_queue_ctrl
`default_nettype wire

// [hqt_tx_queue_ctrl_props.sv]
// Assertions on the transmit queue control ports
`timescale 1ns/1ps
`default_nettype none
module hqt_tx_queue_ctrl_props (
  // Clock, reset and register port
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [8:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  // Stream and flow control
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_LAST_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic FULL_DUPLEX_I,
  input wire logic RX_BUF_HIGH_I,
  input wire logic PAUSE_REQ_O,
  input wire logic BACKPRESSURE_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  AST_PAUSE_CAUSE: assert property (PAUSE_REQ_O |-> $past(RX_BUF_HIGH_I) &&
    !$past(RX_BUF_HIGH_I, 2) && $past(FULL_DUPLEX_I)) else $error("pause without cause");
  AST_PAUSE_PULSE: assert property (PAUSE_REQ_O |=> !PAUSE_REQ_O)
    else $error("pause request too long");
  AST_BP_CAUSE: assert property (BACKPRESSURE_O |->
    $past(RX_BUF_HIGH_I) && !$past(FULL_DUPLEX_I)) else $error("backpressure without cause");
  AST_FC_EXCL: assert property (!(PAUSE_REQ_O && BACKPRESSURE_O))
    else $error("pause and backpressure together");
  AST_TX_HOLD: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O &&
    $stable(TX_DATA_O) && $stable(TX_LAST_O)) else $error("byte not held");
  AST_RD_HOLD: assert property (!$past(REG_RD_I) |-> $stable(REG_RDATA_O))
    else $error("read data changed without read");
  AST_UNMAPPED: assert property (REG_RD_I && REG_ADDR_I != 9'h170 && REG_ADDR_I != 9'h172 &&
    REG_ADDR_I != 9'h174 |=> REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
  AST_CTRL_RSVD: assert property (REG_RD_I && REG_ADDR_I == 9'h170 |=>
    (REG_RDATA_O & 16'hFE02) == 16'h0000) else $error("control reserved bits set");
  AST_STAT_RSVD: assert property (REG_RD_I && REG_ADDR_I == 9'h172 |=>
    (REG_RDATA_O & 16'hCFC0) == 16'h0000) else $error("status reserved bits set");
endmodule // hqt_tx_queue_ctrl_props
`default_nettype wire

// [hqt_tx_queue_ctrl_regs.vh]
// Register offsets, field positions, reset values and timing for the transmit queue control
`ifndef HQT_TX_QUEUE_CTRL_REGS_VH
`define HQT_TX_QUEUE_CTRL_REGS_VH

`define HQT_ADDR_W 9
`define HQT_OFS_TX_CTRL 9'h170
`define HQT_OFS_TX_STAT 9'h172
`define HQT_OFS_RX_CTRL1 9'h174

`define HQT_TXC_ICMP_CSUM 8
`define HQT_TXC_UDP_CSUM 7
`define HQT_TXC_TCP_CSUM 6
`define HQT_TXC_FLUSH 5
`define HQT_TXC_FLOW_CTRL 4
`define HQT_TXC_PAD 3
`define HQT_TXC_CRC 2
`define HQT_TXC_ENABLE 0
`define HQT_TXC_WR_MASK 16'h01FD
`define HQT_TXC_RESET 16'h0000

`define HQT_TXS_LATE_COL 13
`define HQT_TXS_MAX_COL 12
`define HQT_TXS_FID_HI 5
`define HQT_TXS_FID_LO 0
`define HQT_FID_W 6

`define HQT_RXC_FLUSH 15
`define HQT_RXC_FLOW_CTRL 10
`define HQT_RXC_ENABLE 0
`define HQT_RXC_RESET 16'h0800

`define HQT_MIN_DATA_BYTES 7'd60
`define HQT_CRC_BYTES 3'd4
`define HQT_CRC_INIT 32'hFFFF_FFFF
`define HQT_CRC_POLY 32'hEDB8_8320

`define HQT_CLK_PERIOD_NS 8
`define HQT_PAUSE_QUANTUM_NS 5120
`define HQT_PAUSE_QUANTUM_CYC (`HQT_PAUSE_QUANTUM_NS / `HQT_CLK_PERIOD_NS)

`endif

// [tb_top.sv]
// Self-checking bench for the transmit queue control
`timescale 1ns/1ps
`default_nettype none
`include "hqt_tx_queue_ctrl_regs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] be = 2'b11;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] ind = 8'h00;
  logic inl = 1'b0;
  logic [5:0] fid = 6'h00;
  logic inv = 1'b0;
  logic [1:0] col_in = 2'b00;
  logic slow = 1'b0;
  logic fd = 1'b0;
  logic bh = 1'b0;
  logic rxp = 1'b0;
  logic [15:0] rxq = 16'h0000;
  logic [15:0] rdata;
  logic [7:0] txd;
  logic [1:0] col;
  logic inr, txl, txv, txr, done, pq, bp, ci, cu, ct, tfl, rfl, ren, run;
  int mismatches = 0;
  int checks_done = 0;
  int npq = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (pq) npq <= npq + 1;
  hqt_tx_queue_ctrl i_dut (
    .SYS_CLK_I(clk), .RSTN_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_BE_I(be), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .IN_DATA_I(ind),
    .IN_LAST_I(inl), .IN_FID_I(fid), .IN_VALID_I(inv), .IN_READY_O(inr), .TX_DATA_O(txd),
    .TX_LAST_O(txl), .TX_VALID_O(txv), .TX_READY_I(txr), .TX_DONE_I(done),
    .TX_LATE_COL_I(col[1]), .TX_MAX_COL_I(col[0]), .FULL_DUPLEX_I(fd), .RX_BUF_HIGH_I(bh),
    .RX_PAUSE_I(rxp), .RX_PAUSE_QUANTA_I(rxq), .PAUSE_REQ_O(pq), .BACKPRESSURE_O(bp),
    .TX_CSUM_ICMP_O(ci), .TX_CSUM_UDP_O(cu), .TX_CSUM_TCP_O(ct), .TX_FLUSH_O(tfl),
    .RX_FLUSH_O(rfl), .RX_ENABLE_O(ren), .TX_RUNNING_O(run));
  hqt_mac_model i_mac (.clk_i(clk), .rst_n_i(rst_n), .data_i(txd), .last_i(txl),
    .valid_i(txv), .slow_i(slow), .col_i(col_in), .ready_o(txr), .done_o(done), .col_o(col));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 500) begin
      mismatches++;
      $display("unexpected wait timeout");
      summarize();
    end
  endtask
  task automatic wreg(input logic [8:0] a, input logic [15:0] d, input logic [1:0] b);
    @(negedge clk);
    addr = a;
    wdata = d;
    be = b;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [8:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    cmp($sformatf("register %h", a), e, rdata);
  endtask
  task automatic send(input int n, input logic [5:0] f);
    int k;
    for (int i = 0; i < n; i++) begin
      ind = 8'h50 + i[7:0];
      inl = (i == n - 1);
      fid = f;
      inv = 1'b1;
      k = 0;
      while (inr !== 1'b1 && k < 500) begin
        @(negedge clk);
        k++;
      end
      bound(k);
      @(negedge clk);
    end
    inv = 1'b0;
  endtask
  task automatic wait_valid();
    int k;
    k = 0;
    while (txv !== 1'b1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    bound(k);
  endtask
  task automatic wait_frames(input int t);
    int k;
    k = 0;
    while (i_mac.nf < t && k < 500) begin
      @(negedge clk);
      k++;
    end
    bound(k);
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] d);
    for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ d[j]) ? `HQT_CRC_POLY : 32'h0000_0000);
    return c;
  endfunction
  task automatic chk_frame(input int n, input bit pad, input bit fcs);
    logic [31:0] c;
    logic [7:0] e;
    int len;
    c = `HQT_CRC_INIT;
    len = (pad && n < 60) ? 60 : n;
    for (int i = 0; i < len; i++) begin
      e = (i < n) ? 8'h50 + i[7:0] : 8'h00;
      cmp("tx byte", e, i_mac.bytes[i]);
      c = crc(c, e);
    end
    // Check value goes out inverted, low byte first
    for (int i = 0; i < 4; i++) if (fcs) cmp("crc byte", (~c >> (8 * i)) & 32'h0000_00FF,
      i_mac.bytes[len + i]);
    cmp("tx length", len + (fcs ? 4 : 0), i_mac.len);
  endtask
  task automatic t_regs();
    rreg(9'h170, 16'h0000);
    rreg(9'h172, 16'h0000);
    rreg(9'h174, 16'h0800);
    rreg(9'h17E, 16'h0000);
    // Enable kept clear while flush is set
    wreg(9'h170, 16'hFFFE, 2'b01);
    rreg(9'h170, 16'h00FC);
    wreg(9'h170, 16'hFFFE, 2'b11);
    rreg(9'h170, 16'h01FC);
    wreg(9'h172, 16'hFFFF, 2'b11);
    rreg(9'h172, 16'h0000);
    wreg(9'h170, 16'h0000, 2'b11);
    $display("test registers done");
  endtask
  task automatic t_pad();
    wreg(9'h170, 16'h01CD, 2'b11);
    col_in = 2'b10;
    slow = 1'b1;
    send(1, 6'h05);
    wait_valid();
    cmp("checksum requests", 3'b111, {ci, cu, ct});
    wait_frames(1);
    chk_frame(1, 1'b1, 1'b1);
    rreg(9'h172, 16'h2005);
    $display("test padded frame done");
  endtask
  task automatic t_held();
    wreg(9'h170, 16'h0000, 2'b11);
    col_in = 2'b01;
    repeat (2) @(negedge clk);
    cmp("running", 1'b0, run);
    fork
      send(3, 6'h09);
      begin
        repeat (8) @(negedge clk);
        cmp("valid while stopped", 1'b0, txv);
        wreg(9'h170, 16'h0001, 2'b11);
        wait_valid();
        cmp("running", 1'b1, run);
        cmp("checksum requests", 3'b000, {ci, cu, ct});
        wreg(9'h170, 16'h0000, 2'b11);
      end
    join
    wait_frames(2);
    chk_frame(3, 1'b0, 1'b0);
    cmp("running", 1'b0, run);
    rreg(9'h172, 16'h1009);
    $display("test stop mid frame done");
  endtask
  task automatic t_flow();
    wreg(9'h170, 16'h0011, 2'b11);
    fd = 1'b1;
    bh = 1'b1;
    repeat (3) @(negedge clk);
    cmp("pause pulses", 1, npq);
    bh = 1'b0;
    fd = 1'b0;
    @(negedge clk);
    bh = 1'b1;
    repeat (2) @(negedge clk);
    cmp("backpressure", 1'b1, bp);
    wreg(9'h170, 16'h0000, 2'b11);
    repeat (2) @(negedge clk);
    cmp("backpressure", 1'b0, bp);
    fd = 1'b1;
    bh = 1'b0;
    @(negedge clk);
    bh = 1'b1;
    repeat (3) @(negedge clk);
    cmp("pause pulses", 1, npq);
    bh = 1'b0;
    $display("test flow control done");
  endtask
  task automatic t_flush();
    send(1, 6'h03);
    wreg(9'h170, 16'h0020, 2'b11);
    repeat (2) @(negedge clk);
    cmp("input ready", 1'b0, inr);
    cmp("tx flush", 1'b1, tfl);
    wreg(9'h170, 16'h0000, 2'b11);
    wreg(9'h170, 16'h0001, 2'b11);
    repeat (20) @(negedge clk);
    cmp("frames after flush", 2, i_mac.nf);
    wreg(9'h174, 16'h8000, 2'b11);
    repeat (2) @(negedge clk);
    cmp("rx flush", 2'b10, {rfl, ren});
    wreg(9'h174, 16'h0001, 2'b11);
    repeat (2) @(negedge clk);
    cmp("rx flush", 2'b01, {rfl, ren});
    rreg(9'h174, 16'h0001);
    $display("test flush done");
  endtask
  task automatic t_pause();
    wreg(9'h174, 16'h0400, 2'b11);
    wreg(9'h170, 16'h0001, 2'b11);
    fd = 1'b1;
    rxq = 16'h0001;
    rxp = 1'b1;
    @(negedge clk);
    rxp = 1'b0;
    send(1, 6'h0A);
    // One quantum is 640 cycles; frame must still wait
    repeat (600) @(negedge clk);
    cmp("valid while paused", 1'b0, txv);
    wait_valid();
    wait_frames(3);
    cmp("frames after pause", 3, i_mac.nf);
    rreg(9'h172, 16'h100A);
    $display("test pause done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_regs();
    t_pad();
    t_held();
    t_flow();
    t_flush();
    t_pause();
    summarize();
  end
endmodule // tb_top
bind hqt_tx_queue_ctrl hqt_tx_queue_ctrl_props i_props (.SYS_CLK_I(SYS_CLK_I),
  .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .TX_DATA_O(TX_DATA_O), .TX_LAST_O(TX_LAST_O), .TX_VALID_O(TX_VALID_O),
  .TX_READY_I(TX_READY_I), .FULL_DUPLEX_I(FULL_DUPLEX_I), .RX_BUF_HIGH_I(RX_BUF_HIGH_I),
  .PAUSE_REQ_O(PAUSE_REQ_O), .BACKPRESSURE_O(BACKPRESSURE_O));
`default_nettype wire
